// >>> core/uec_pkg.sv
`default_nettype none
package uec_pkg;
	localparam int PADDR_W = 12;
	localparam int FILL_W = 6;
	localparam int LEVEL_CODE_W = 3;
	localparam int IRQ_W = 4;

	localparam logic [PADDR_W-1:0] CTRL_OFFSET = 12'h000;
	localparam logic [PADDR_W-1:0] LEVEL_OFFSET = 12'h004;
	localparam logic [PADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h008;
	localparam logic [PADDR_W-1:0] IRQ_MASK_OFFSET = 12'h00C;
	localparam logic [PADDR_W-1:0] RUN_STATE_OFFSET = 12'h010;

	localparam int UNIT_EN_BIT = 0;
	localparam int TX_EN_BIT = 8;
	localparam int RX_EN_BIT = 9;
	localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000CF87;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;

	localparam int TX_LEVEL_LSB = 0;
	localparam int RX_LEVEL_LSB = 3;
	localparam logic [31:0] LEVEL_WRITE_MASK = 32'h0000003F;
	localparam logic [31:0] LEVEL_RESET = 32'h00000000;

	localparam int IRQ_RX_LEVEL = 0;
	localparam int IRQ_TX_LEVEL = 1;
	localparam int IRQ_TX_STOP = 2;
	localparam int IRQ_RX_STOP = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	localparam int STATE_TX_RUN = 0;
	localparam int STATE_RX_RUN = 1;
	localparam int STATE_TX_BUSY = 2;
	localparam int STATE_RX_BUSY = 3;

	// Fill thresholds for a 32-entry FIFO
	localparam logic [LEVEL_CODE_W-1:0] CODE_EIGHTH = 3'h0;
	localparam logic [LEVEL_CODE_W-1:0] CODE_QUARTER = 3'h1;
	localparam logic [LEVEL_CODE_W-1:0] CODE_HALF = 3'h2;
	localparam logic [LEVEL_CODE_W-1:0] CODE_3QUARTER = 3'h3;
	localparam logic [LEVEL_CODE_W-1:0] CODE_7EIGHTH = 3'h4;
	localparam logic [FILL_W-1:0] FILL_EIGHTH = 6'h04;
	localparam logic [FILL_W-1:0] FILL_QUARTER = 6'h08;
	localparam logic [FILL_W-1:0] FILL_HALF = 6'h10;
	localparam logic [FILL_W-1:0] FILL_3QUARTER = 6'h18;
	localparam logic [FILL_W-1:0] FILL_7EIGHTH = 6'h1C;

	typedef enum logic [1:0] {RUN_OFF, RUN_ON, RUN_DRAIN} uec_run_type;
	typedef enum logic {BUS_IDLE, BUS_ANSWER} uec_bus_type;
endpackage
`default_nettype wire

// >>> core/uec_level_cross.sv
`timescale 1ns/1ps
`default_nettype none
module uec_level_cross
	import uec_pkg::*;
#(
	parameter bit AT_OR_BELOW = 1'b0
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [FILL_W-1:0] fill_level,
	input wire logic [LEVEL_CODE_W-1:0] level_code,
	output logic crossed
);
	logic [FILL_W-1:0] prev_level;
	logic prev_hit;
	logic [FILL_W-1:0] next_prev_level;
	logic next_prev_hit;
	logic code_valid;
	logic [FILL_W-1:0] threshold;
	logic hit;

	always_comb
	begin
		code_valid = 1'b1;
		case (level_code)
			CODE_EIGHTH: threshold = FILL_EIGHTH; // [RULE_09] [RULE_10]
			CODE_QUARTER: threshold = FILL_QUARTER;
			CODE_HALF: threshold = FILL_HALF;
			CODE_3QUARTER: threshold = FILL_3QUARTER;
			CODE_7EIGHTH: threshold = FILL_7EIGHTH;
			default:
			begin
				// Reserved codes never fire
				threshold = FILL_EIGHTH;
				code_valid = 1'b0;
			end
		endcase
		if (AT_OR_BELOW)
			hit = code_valid && (fill_level <= threshold); // [RULE_10]
		else
			hit = code_valid && (fill_level >= threshold); // [RULE_09]
		// Only a level move into the band counts, not a code change
		crossed = hit && !prev_hit && (fill_level != prev_level); // [RULE_11]
		next_prev_level = fill_level;
		next_prev_hit = hit;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_level <= '0;
			prev_hit <= 1'b0;
		end
		else
		begin
			prev_level <= next_prev_level;
			prev_hit <= next_prev_hit;
		end
	end

	single_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
		crossed |=> !crossed)
		else $error("level crossing reported on two cycles in a row");
endmodule
`default_nettype wire

// >>> core/uec_control.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Control bit 9 enables reception when one and disables the receiver when zero.
// [RULE_02] Clearing receive enable mid-frame lets that frame finish before the receiver stops.
// [RULE_03] Control bit 8 enables transmission when one and disables the transmitter when zero.
// [RULE_04] Clearing transmit enable mid-frame lets that frame finish before the transmitter stops.
// [RULE_05] Control bit 0 is the global enable and when zero disables the whole unit whatever bits 8 and 9 say.
// [RULE_06] Clearing the global enable mid-frame lets the current frame finish before the unit halts.
// [RULE_07] Unused control bits 31-16, 13-12 and 6-3 read as a value software must not rely on.
// [RULE_08] Software writes zero to writable reserved control bits 15, 14, 11, 10, 7, 2 and 1.
// [RULE_09] Receive level codes 000 to 100 select at least 1/8, 1/4, 1/2, 3/4 or 7/8 full; others are reserved.
// [RULE_10] Transmit level codes 000 to 100 select at most 1/8, 1/4, 1/2, 3/4 or 7/8 full.
// [RULE_11] A FIFO interrupt fires when the fill level crosses the threshold, not while it stays beyond it.
module uec_control
	import uec_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_frame_busy,
	input wire logic rx_frame_busy,
	input wire logic [FILL_W-1:0] tx_fill_level,
	input wire logic [FILL_W-1:0] rx_fill_level,
	output logic tx_run,
	output logic rx_run,
	output logic [LEVEL_CODE_W-1:0] tx_irq_level,
	output logic [LEVEL_CODE_W-1:0] rx_irq_level,
	output logic irq
);
	function automatic uec_run_type run_step(input uec_run_type state, input logic enable, input logic busy);
		uec_run_type result;
		result = state;
		case (state)
			RUN_OFF:
				if (enable)
					result = RUN_ON;
			RUN_ON:
				if (!enable)
					result = busy ? RUN_DRAIN : RUN_OFF;
			RUN_DRAIN:
				if (enable)
					result = RUN_ON;
				else if (!busy)
					result = RUN_OFF;
			default:
				result = RUN_OFF;
		endcase
		return result;
	endfunction

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] merged;
		merged = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				merged[i*8 +: 8] = data[i*8 +: 8];
		return merged & mask;
	endfunction

	logic [31:0] ctrl_reg;
	logic [31:0] level_reg;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	uec_bus_type bus_state;
	uec_run_type tx_state;
	uec_run_type rx_state;

	logic [31:0] next_ctrl_reg;
	logic [31:0] next_level_reg;
	logic [IRQ_W-1:0] next_irq_status;
	logic [IRQ_W-1:0] next_irq_mask;
	uec_bus_type next_bus_state;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	uec_run_type next_tx_state;
	uec_run_type next_rx_state;
	logic next_irq;

	logic setup_phase;
	logic write_done;
	logic addr_hit;
	logic tx_enable;
	logic rx_enable;
	logic tx_crossed;
	logic rx_crossed;
	logic [IRQ_W-1:0] irq_events;
	logic status_write;

	assign setup_phase = psel && !penable;
	assign write_done = psel && penable && pready && pwrite && !pslverr;
	assign addr_hit = (paddr == CTRL_OFFSET) || (paddr == LEVEL_OFFSET) || (paddr == IRQ_STATUS_OFFSET)
		|| (paddr == IRQ_MASK_OFFSET) || (paddr == RUN_STATE_OFFSET);
	assign status_write = write_done && (paddr == IRQ_STATUS_OFFSET) && pstrb[0];

	// APB slave: pready rises in the first access cycle, one wait-free answer
	always_comb
	begin
		next_bus_state = bus_state;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		case (bus_state)
			BUS_IDLE:
				if (setup_phase)
				begin
					next_bus_state = BUS_ANSWER;
					next_pready = 1'b1;
					next_pslverr = !addr_hit;
					next_prdata = 32'h00000000;
					if (!pwrite)
						case (paddr)
							// Undefined bits read as zero
							CTRL_OFFSET: next_prdata = ctrl_reg & CTRL_WRITE_MASK; // [RULE_07]
							LEVEL_OFFSET: next_prdata = level_reg & LEVEL_WRITE_MASK;
							IRQ_STATUS_OFFSET: next_prdata = {28'h0000000, irq_status};
							IRQ_MASK_OFFSET: next_prdata = {28'h0000000, irq_mask};
							RUN_STATE_OFFSET: next_prdata = {28'h0000000, rx_frame_busy, tx_frame_busy, rx_run, tx_run};
							default: next_prdata = 32'h00000000;
						endcase
				end
			BUS_ANSWER:
				next_bus_state = BUS_IDLE;
			default:
				next_bus_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_state <= BUS_IDLE;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			bus_state <= next_bus_state;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Register file
	always_comb
	begin
		next_ctrl_reg = ctrl_reg;
		next_level_reg = level_reg;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		if (write_done)
			case (paddr)
				// Writable reserved bits are stored as written; software keeps them zero
				CTRL_OFFSET: next_ctrl_reg = byte_merge(ctrl_reg, pwdata, pstrb, CTRL_WRITE_MASK); // [RULE_08]
				LEVEL_OFFSET: next_level_reg = byte_merge(level_reg, pwdata, pstrb, LEVEL_WRITE_MASK);
				IRQ_MASK_OFFSET:
					if (pstrb[0])
						next_irq_mask = pwdata[IRQ_W-1:0];
				IRQ_STATUS_OFFSET:
					if (pstrb[0])
						next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
				default: next_irq_status = irq_status;
			endcase
		// A new event wins over a same-cycle clear
		next_irq_status = next_irq_status | irq_events; // [RULE_11]
		next_irq = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= CTRL_RESET;
			level_reg <= LEVEL_RESET;
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
			irq <= 1'b0;
		end
		else
		begin
			ctrl_reg <= next_ctrl_reg;
			level_reg <= next_level_reg;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			irq <= next_irq;
		end
	end

	// Run control: the global bit gates both directions
	assign tx_enable = ctrl_reg[UNIT_EN_BIT] && ctrl_reg[TX_EN_BIT]; // [RULE_03] [RULE_05]
	assign rx_enable = ctrl_reg[UNIT_EN_BIT] && ctrl_reg[RX_EN_BIT]; // [RULE_01] [RULE_05]

	always_comb
	begin
		// A frame in flight keeps the direction in drain until it ends
		next_tx_state = run_step(tx_state, tx_enable, tx_frame_busy); // [RULE_04] [RULE_06]
		next_rx_state = run_step(rx_state, rx_enable, rx_frame_busy); // [RULE_02] [RULE_06]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state <= RUN_OFF;
			rx_state <= RUN_OFF;
			tx_run <= 1'b0;
			rx_run <= 1'b0;
			tx_irq_level <= '0;
			rx_irq_level <= '0;
		end
		else
		begin
			tx_state <= next_tx_state;
			rx_state <= next_rx_state;
			tx_run <= (next_tx_state != RUN_OFF);
			rx_run <= (next_rx_state != RUN_OFF);
			tx_irq_level <= next_level_reg[TX_LEVEL_LSB +: LEVEL_CODE_W];
			rx_irq_level <= next_level_reg[RX_LEVEL_LSB +: LEVEL_CODE_W];
		end
	end

	always_comb
	begin
		irq_events = '0;
		irq_events[IRQ_RX_LEVEL] = rx_crossed;
		irq_events[IRQ_TX_LEVEL] = tx_crossed;
		irq_events[IRQ_TX_STOP] = (tx_state != RUN_OFF) && (next_tx_state == RUN_OFF);
		irq_events[IRQ_RX_STOP] = (rx_state != RUN_OFF) && (next_rx_state == RUN_OFF);
	end

	uec_level_cross #(
		.AT_OR_BELOW(1'b1)
	) tx_cross (
		.pclk(pclk),
		.presetn(presetn),
		.fill_level(tx_fill_level),
		.level_code(level_reg[TX_LEVEL_LSB +: LEVEL_CODE_W]),
		.crossed(tx_crossed)
	);

	uec_level_cross #(
		.AT_OR_BELOW(1'b0)
	) rx_cross (
		.pclk(pclk),
		.presetn(presetn),
		.fill_level(rx_fill_level),
		.level_code(level_reg[RX_LEVEL_LSB +: LEVEL_CODE_W]),
		.crossed(rx_crossed)
	);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence unit_idle_s;
		!ctrl_reg[UNIT_EN_BIT] && !tx_frame_busy && !rx_frame_busy;
	endsequence

	sequence ctrl_read_s;
		psel && penable && pready && !pwrite && (paddr == CTRL_OFFSET);
	endsequence

	// One answer per transfer; a second pulse would complete a phantom access
	sequence answer_pulse_s;
		pready ##1 !pready;
	endsequence

	rx_enable_start_a: assert property (rx_state == RUN_OFF // [RULE_01]
		&& ctrl_reg[RX_EN_BIT] && ctrl_reg[UNIT_EN_BIT] |=> rx_run)
		else $error("receiver did not start after enable");
	rx_drain_hold_a: assert property (rx_run && rx_frame_busy |=> rx_run) // [RULE_02]
		else $error("receiver stopped inside a frame");
	tx_enable_start_a: assert property (tx_state == RUN_OFF // [RULE_03]
		&& ctrl_reg[TX_EN_BIT] && ctrl_reg[UNIT_EN_BIT] |=> tx_run)
		else $error("transmitter did not start after enable");
	tx_drain_hold_a: assert property (tx_run && tx_frame_busy |=> tx_run) // [RULE_04]
		else $error("transmitter stopped inside a frame");
	unit_off_halt_a: assert property (unit_idle_s ##1 unit_idle_s |-> !tx_run && !rx_run) // [RULE_05]
		else $error("unit still running with global enable clear");
	unit_drain_end_a: assert property ($fell(ctrl_reg[UNIT_EN_BIT]) && tx_run && tx_frame_busy // [RULE_06]
		|=> tx_run ##0 (tx_state == RUN_DRAIN))
		else $error("transmitter did not drain after global disable");
	reserved_read_a: assert property (ctrl_read_s // [RULE_07]
		|-> (prdata[31:16] == 16'h0000) && (prdata[13:12] == 2'h0) && (prdata[6:3] == 4'h0))
		else $error("unused control bits read nonzero");
	// A clear in the cycle after the event may legitimately drop the bit
	rx_cross_sticky_a: assert property (rx_crossed ##1 !(status_write && pwdata[IRQ_RX_LEVEL]) // [RULE_11]
		|-> irq_status[IRQ_RX_LEVEL] [*2])
		else $error("receive level crossing not held in status");
	tx_cross_sticky_a: assert property (tx_crossed ##1 !(status_write && pwdata[IRQ_TX_LEVEL]) // [RULE_11]
		|-> irq_status[IRQ_TX_LEVEL] [*2])
		else $error("transmit level crossing not held in status");
	irq_output_a: assert property (irq == |(irq_status & irq_mask))
		else $error("interrupt output disagrees with status and mask");

	// Bus answer and refusals
	apb_answer_a: assert property (bus_state == BUS_IDLE && setup_phase |=> answer_pulse_s)
		else $error("bus answer missing or longer than one cycle");
	bad_addr_err_a: assert property (bus_state == BUS_IDLE && setup_phase && !addr_hit
		|=> pslverr && (prdata == 32'h00000000))
		else $error("unmapped address answered without error");
	bad_addr_keep_a: assert property (psel && penable && pready && pwrite && pslverr
		|=> $stable(ctrl_reg) && $stable(level_reg))
		else $error("refused write changed a register");

	// Status and mask handling
	mask_write_a: assert property (write_done && (paddr == IRQ_MASK_OFFSET) && pstrb[0]
		|=> irq_mask == $past(pwdata[IRQ_W-1:0]))
		else $error("interrupt mask write lost");
	// Without a same-cycle event, every bit written as one must be gone
	status_clear_a: assert property (status_write && (irq_events == '0)
		|=> (irq_status & $past(pwdata[IRQ_W-1:0])) == '0)
		else $error("status bit survived a clear");

	// Run control: drain end, stop flags and gating
	rx_drain_end_a: assert property (rx_state == RUN_DRAIN // [RULE_02]
		&& !rx_enable && !rx_frame_busy |=> !rx_run)
		else $error("receiver kept running after its last frame");
	tx_drain_end_a: assert property (tx_state == RUN_DRAIN // [RULE_04]
		&& !tx_enable && !tx_frame_busy |=> !tx_run)
		else $error("transmitter kept running after its last frame");
	rx_unit_drain_a: assert property ($fell(ctrl_reg[UNIT_EN_BIT]) && rx_run && rx_frame_busy // [RULE_06]
		|=> rx_run ##0 (rx_state == RUN_DRAIN))
		else $error("receiver did not drain after global disable");
	tx_stop_flag_a: assert property ($fell(tx_run) |-> irq_status[IRQ_TX_STOP]) // [RULE_04]
		else $error("transmitter stop not flagged");
	rx_stop_flag_a: assert property ($fell(rx_run) |-> irq_status[IRQ_RX_STOP]) // [RULE_02]
		else $error("receiver stop not flagged");
	unit_gate_a: assert property (!ctrl_reg[UNIT_EN_BIT] && tx_state == RUN_OFF && rx_state == RUN_OFF // [RULE_05]
		|=> !tx_run && !rx_run)
		else $error("a direction started with the unit disabled");
endmodule
`default_nettype wire

// >>> dv/uec_frame_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for one frame engine; a frame only starts while run is high
module uec_frame_model
#(
	parameter int LEN = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic go,
	output logic busy
);
	int left;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left <= 0;
			busy <= 1'b0;
		end
		else if (left > 1)
			left <= left - 1;
		else if (left == 1)
		begin
			left <= 0;
			busy <= 1'b0;
		end
		else if (go && run)
		begin
			left <= LEN;
			busy <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> dv/uart_enable_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_enable_control_tb;
	import uec_pkg::*;
	localparam int LEN = 12;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [PADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready, pslverr, tx_busy, rx_busy, tx_run, rx_run, irq;
	logic [FILL_W-1:0] tx_fill = '0;
	logic [FILL_W-1:0] rx_fill = '0;
	logic [LEVEL_CODE_W-1:0] tx_lvl, rx_lvl;
	logic tx_go = 1'b0;
	logic rx_go = 1'b0;
	logic [31:0] q;
	logic e;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int thr, msk, sts;
	int frac[5] = '{1, 2, 4, 6, 7};

	always #5 pclk = ~pclk;

	uec_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_frame_busy(tx_busy), .rx_frame_busy(rx_busy), .tx_fill_level(tx_fill), .rx_fill_level(rx_fill),
		.tx_run(tx_run), .rx_run(rx_run), .tx_irq_level(tx_lvl), .rx_irq_level(rx_lvl), .irq(irq));
	uec_frame_model #(.LEN(LEN)) tx_eng (.pclk(pclk), .presetn(presetn), .run(tx_run), .go(tx_go), .busy(tx_busy));
	uec_frame_model #(.LEN(LEN)) rx_eng (.pclk(pclk), .presetn(presetn), .run(rx_run), .go(rx_go), .busy(rx_busy));

	task automatic conclude;
		$display("counts: tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Outputs are read in the active region, before this edge's updates land
	task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdchk(input logic [PADDR_W-1:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h00000000, q, e);
		chk(q, x);
	endtask

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(32'h73CC1B16));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(CTRL_OFFSET, CTRL_RESET);
		rdchk(LEVEL_OFFSET, LEVEL_RESET);
		rdchk(IRQ_STATUS_OFFSET, 32'h00000000);
		rdchk(IRQ_MASK_OFFSET, 32'h00000000);
		rdchk(RUN_STATE_OFFSET, 32'h00000000);
		apb(1'b0, 12'h0FC, 32'h00000000, q, e);
		chk(e, 32'h00000001);
		chk(q, 32'h00000000);
		apb(1'b1, 12'h0FC, 32'hFFFFFFFF, q, e);
		chk(e, 32'h00000001);
		rdchk(CTRL_OFFSET, CTRL_RESET);
		$display("test reset and unmapped done");

		for (int i = 0; i < 8; i++)
		begin
			wr(CTRL_OFFSET, {22'h0, i[2], i[1], 7'h0, i[0]});
			rdchk(CTRL_OFFSET, {22'h0, i[2], i[1], 7'h0, i[0]});
			chk(tx_run, i[0] & i[1]);
			chk(rx_run, i[0] & i[2]);
		end
		pstrb <= 4'h1;
		wr(CTRL_OFFSET, 32'h00000300);
		pstrb <= 4'hF;
		rdchk(CTRL_OFFSET, 32'h00000300);
		chk(tx_run, 32'h00000000);
		chk(rx_run, 32'h00000000);
		$display("test enable combinations done");

		// Both ways of stopping mid-frame: unit off, then both enables off
		for (int k = 0; k < 2; k++)
		begin
			wr(IRQ_STATUS_OFFSET, 32'h0000000F);
			wr(IRQ_MASK_OFFSET, 32'h0000000C);
			wr(CTRL_OFFSET, 32'h00000301);
			@(posedge pclk);
			tx_go <= 1'b1;
			rx_go <= 1'b1;
			@(posedge pclk);
			tx_go <= 1'b0;
			rx_go <= 1'b0;
			wr(CTRL_OFFSET, (k == 0) ? 32'h00000300 : 32'h00000001);
			repeat (2) @(posedge pclk);
			chk(tx_run, 32'h00000001);
			chk(rx_run, 32'h00000001);
			rdchk(RUN_STATE_OFFSET, 32'h0000000F);
			repeat (LEN + 4) @(posedge pclk);
			chk(tx_run, 32'h00000000);
			chk(rx_run, 32'h00000000);
			rdchk(IRQ_STATUS_OFFSET, 32'h0000000C);
			chk(irq, 32'h00000001);
			wr(IRQ_STATUS_OFFSET, 32'h0000000C);
			repeat (2) @(posedge pclk);
			chk(irq, 32'h00000000);
		end
		$display("test graceful stop done");

		// Reserved codes 5 to 7 must stay silent
		for (int c = 0; c < 8; c++)
		begin
			thr = (c < 5) ? 32 * frac[c] / 8 : 16;
			sts = (c < 5) ? 3 : 0;
			msk = $urandom_range(0, 15);
			wr(LEVEL_OFFSET, (c << 3) | c);
			wr(IRQ_MASK_OFFSET, msk);
			rx_fill <= 6'h00;
			tx_fill <= 6'h20;
			repeat (3) @(posedge pclk);
			wr(IRQ_STATUS_OFFSET, 32'h0000000F);
			chk(tx_lvl, c);
			chk(rx_lvl, c);
			rx_fill <= 6'(thr);
			tx_fill <= 6'(thr);
			repeat (3) @(posedge pclk);
			rdchk(IRQ_STATUS_OFFSET, sts);
			chk(irq, |(sts & msk));
			rx_fill <= 6'(thr + 1 + $urandom_range(0, 31 - thr));
			tx_fill <= 6'($urandom_range(0, thr - 1));
			repeat (3) @(posedge pclk);
			wr(IRQ_STATUS_OFFSET, 32'h0000000F);
			repeat (2) @(posedge pclk);
			rdchk(IRQ_STATUS_OFFSET, 32'h00000000);
		end
		$display("test level thresholds done");
		conclude();
	end
endmodule
`default_nettype wire
